// ---- core/time_interval_counter.sv ----
// Functional notes
// - count from crystal, also during power-down
// - register accesses finish on crystal ticks
// - fraction counts 0..127, wrap steps seconds
// - seconds count 0..59, wrap steps minutes
// - minutes count 0..59, wrap steps hours
// - hours wrap at 23 or 255
// - base select picks interval step source
// - interval count equals target sets flag
// - flag raises interrupt, held until cleared
// - flag wakes part from power-down
// - one-shot clears enable, else reload
// - interval enable runs or clears counter
// - clock disable restores last written time
// - control bit 7 ignores writes
// - all registers reset to zero
module time_interval_counter (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic xtal_in,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic tic_irq_enable,
    input wire logic power_down,
    output logic [7:0] sfr_rdata,
    output logic sfr_busy,
    output logic irq_req,
    output logic wake_req
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic xtal_tick; // one cycle per crystal rising edge
    logic frac_step; // one cycle per 1/128 s
    tic_pkg::access_state_t acc_state; // access sequencer
    logic [7:0] pend_addr; // address held until the crystal tick
    logic [7:0] pend_data; // write data held likewise
    logic pend_wr; // held access is a write
    logic apply; // held access completes this cycle
    logic apply_wr; // completing access is a write
    logic [7:0] control; // timekeeper_control
    logic [7:0] frac; // fraction_count
    logic [7:0] sec; // s_unit_count
    logic [7:0] min; // m_unit_count
    logic [7:0] hour; // hour_count
    logic [7:0] target; // interval_target
    logic [7:0] frac_last; // last software-written time values
    logic [7:0] sec_last;
    logic [7:0] min_last;
    logic [7:0] hour_last;
    logic [7:0] long_interval_counter; // interval count
    logic timebase_clock_enable;
    logic interval_count_enable;
    logic interval_match_flag;
    logic one_shot_select;
    logic day_hour_select;
    tic_pkg::base_t base_sel;
    logic step; // gated fraction step
    logic frac_wrap;
    logic sec_wrap;
    logic min_wrap;
    logic [7:0] hour_top; // wrap point of the hour counter
    logic ival_src; // selected overflow
    logic ival_step; // interval counter advances
    logic [7:0] next_ival; // count after this step
    logic ival_hit; // count reaches target
    logic [7:0] read_mux;

    ////////////////////////////////////////////////////////////////////////////
    // crystal edge and fraction step generator
    xtal_step_gen u_step (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .xtal_in(xtal_in),
        .xtal_tick(xtal_tick),
        .frac_step(frac_step)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register access: held until the next crystal rising edge, then applied
    assign apply = (acc_state == tic_pkg::ACC_BUSY) && xtal_tick;
    assign apply_wr = apply && pend_wr;

    // sequencer; a request while busy or to a foreign address is ignored
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_state <= tic_pkg::ACC_IDLE;
            pend_addr <= tic_pkg::RESET_VALUE;
            pend_data <= tic_pkg::RESET_VALUE;
            pend_wr <= 1'b0;
            sfr_busy <= 1'b0;
        end else begin
            unique case (acc_state)
                tic_pkg::ACC_IDLE: begin
                    if ((sfr_wr || sfr_rd) && sfr_addr >= tic_pkg::OFS_CONTROL
                        && sfr_addr <= tic_pkg::OFS_TARGET) begin
                        pend_addr <= sfr_addr;
                        pend_data <= sfr_wdata;
                        pend_wr <= sfr_wr;
                        acc_state <= tic_pkg::ACC_BUSY;
                        sfr_busy <= 1'b1;
                    end
                end
                tic_pkg::ACC_BUSY: begin
                    // completion waits for the slow clock
                    if (xtal_tick) begin
                        acc_state <= tic_pkg::ACC_IDLE;
                        sfr_busy <= 1'b0;
                    end
                end
                default: begin
                    acc_state <= tic_pkg::ACC_IDLE;
                    sfr_busy <= 1'b0;
                end
            endcase
        end
    end

    // read data taken at completion
    always_comb begin
        unique case (pend_addr)
            tic_pkg::OFS_CONTROL: read_mux = control;
            tic_pkg::OFS_FRAC: read_mux = frac;
            tic_pkg::OFS_SEC: read_mux = sec;
            tic_pkg::OFS_MIN: read_mux = min;
            tic_pkg::OFS_HOUR: read_mux = hour;
            tic_pkg::OFS_TARGET: read_mux = target;
            default: read_mux = tic_pkg::RESET_VALUE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= tic_pkg::RESET_VALUE;
        end else if (apply && !pend_wr) begin
            sfr_rdata <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control field aliases
    assign timebase_clock_enable = control[tic_pkg::CTRL_CLK_EN];
    assign interval_count_enable = control[tic_pkg::CTRL_IVAL_EN];
    assign interval_match_flag = control[tic_pkg::CTRL_FLAG];
    assign one_shot_select = control[tic_pkg::CTRL_ONESHOT];
    assign day_hour_select = control[tic_pkg::CTRL_DAYHOUR];
    assign base_sel = tic_pkg::base_t'(control[tic_pkg::CTRL_BASE_HI:tic_pkg::CTRL_BASE_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // carry chain; power_down is deliberately not looked at here
    assign step = frac_step && timebase_clock_enable;
    assign frac_wrap = step && (frac == tic_pkg::FRAC_LAST);
    assign sec_wrap = frac_wrap && (sec == tic_pkg::SIXTY_LAST);
    assign min_wrap = sec_wrap && (min == tic_pkg::SIXTY_LAST);
    assign hour_top = day_hour_select ? tic_pkg::HOUR_DAY_LAST
                                      : tic_pkg::HOUR_FULL_LAST;

    // interval step source
    always_comb begin
        unique case (base_sel)
            tic_pkg::BASE_FRAC: ival_src = step;
            tic_pkg::BASE_SEC: ival_src = frac_wrap;
            tic_pkg::BASE_MIN: ival_src = sec_wrap;
            tic_pkg::BASE_HOUR: ival_src = min_wrap;
        endcase
    end

    assign ival_step = ival_src && interval_count_enable;
    assign next_ival = long_interval_counter + 8'h01;
    assign ival_hit = ival_step && (next_ival == target);

    ////////////////////////////////////////////////////////////////////////////
    // last written time values, restored while the clock is disabled
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frac_last <= tic_pkg::RESET_VALUE;
            sec_last <= tic_pkg::RESET_VALUE;
            min_last <= tic_pkg::RESET_VALUE;
            hour_last <= tic_pkg::RESET_VALUE;
        end else if (apply_wr) begin
            if (pend_addr == tic_pkg::OFS_FRAC) frac_last <= pend_data;
            if (pend_addr == tic_pkg::OFS_SEC) sec_last <= pend_data;
            if (pend_addr == tic_pkg::OFS_MIN) min_last <= pend_data;
            if (pend_addr == tic_pkg::OFS_HOUR) hour_last <= pend_data;
        end
    end

    // time counters: a write wins, a cleared enable restores, else count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frac <= tic_pkg::RESET_VALUE;
            sec <= tic_pkg::RESET_VALUE;
            min <= tic_pkg::RESET_VALUE;
            hour <= tic_pkg::RESET_VALUE;
        end else if (apply_wr && pend_addr >= tic_pkg::OFS_FRAC
                     && pend_addr <= tic_pkg::OFS_HOUR) begin
            // preloaded time is taken as written
            if (pend_addr == tic_pkg::OFS_FRAC) frac <= pend_data;
            if (pend_addr == tic_pkg::OFS_SEC) sec <= pend_data;
            if (pend_addr == tic_pkg::OFS_MIN) min <= pend_data;
            if (pend_addr == tic_pkg::OFS_HOUR) hour <= pend_data;
        end else if (!timebase_clock_enable) begin
            frac <= frac_last;
            sec <= sec_last;
            min <= min_last;
            hour <= hour_last;
        end else if (step) begin
            frac <= frac_wrap ? 8'h00 : frac + 8'h01;
            if (frac_wrap) sec <= sec_wrap ? 8'h00 : sec + 8'h01;
            if (sec_wrap) min <= min_wrap ? 8'h00 : min + 8'h01;
            if (min_wrap) hour <= (hour == hour_top) ? 8'h00 : hour + 8'h01;
        end
    end

    // interval target, plain storage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            target <= tic_pkg::RESET_VALUE;
        end else if (apply_wr && pend_addr == tic_pkg::OFS_TARGET) begin
            target <= pend_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interval counter; zeroed on the hit so the next period is full length
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            long_interval_counter <= tic_pkg::RESET_VALUE;
        end else if (!interval_count_enable) begin
            long_interval_counter <= 8'h00;
        end else if (ival_hit) begin
            long_interval_counter <= 8'h00;
        end else if (ival_step) begin
            long_interval_counter <= next_ival;
        end
    end

    // control: bit 7 stays zero; a hit sets the flag even during a clearing write
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            control <= tic_pkg::RESET_VALUE;
        end else begin
            if (apply_wr && pend_addr == tic_pkg::OFS_CONTROL) begin
                control <= {1'b0, pend_data[6:0]};
                if (ival_hit) control[tic_pkg::CTRL_FLAG] <= 1'b1;
            end else if (ival_hit) begin
                control[tic_pkg::CTRL_FLAG] <= 1'b1;
                if (one_shot_select) control[tic_pkg::CTRL_IVAL_EN] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt request and wake-up toward the core
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            irq_req <= interval_match_flag && tic_irq_enable;
            wake_req <= interval_match_flag && tic_irq_enable && power_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_frac_wrap:
        assert property (frac_wrap && !apply_wr |=> frac == 8'h00 && $past(sec) != sec)
        else $error("fraction wrap did not clear or step seconds");

    a_sec_wrap:
        assert property (sec_wrap && !apply_wr |=> sec == 8'h00 && min != $past(min))
        else $error("seconds wrap did not clear or step minutes");

    a_min_wrap:
        assert property (min_wrap && !apply_wr |=> min == 8'h00 && hour != $past(hour))
        else $error("minutes wrap did not clear or step hours");

    a_hour_day:
        assert property (min_wrap && !apply_wr && day_hour_select && hour == 8'h17
                         |=> hour == 8'h00)
        else $error("hour did not wrap after 23");

    a_match_flag:
        assert property (ival_hit |=> interval_match_flag && long_interval_counter == 8'h00)
        else $error("match did not set flag and zero the counter");

    a_flag_hold:
        assert property (interval_match_flag && !apply_wr |=> interval_match_flag)
        else $error("flag dropped without software clear");

    a_irq_path:
        assert property (interval_match_flag && tic_irq_enable |=> irq_req ##0
                         (wake_req == $past(power_down)))
        else $error("interrupt or wake request missing");

    a_one_shot:
        assert property (ival_hit && one_shot_select && !apply_wr
                         |=> !interval_count_enable)
        else $error("one-shot timeout left interval enable set");

    a_bit_seven:
        assert property (apply_wr |=> control[tic_pkg::CTRL_UNUSED] == 1'b0)
        else $error("unimplemented control bit took a write");

    a_time_restore:
        assert property (!timebase_clock_enable && !apply_wr ##1 !apply_wr
                         |-> frac == frac_last && hour == hour_last)
        else $error("time not restored while clock disabled");

    a_access_done:
        assert property (apply |=> !sfr_busy ##0 $stable(pend_addr))
        else $error("access did not complete on crystal tick");

endmodule

// ---- include/tic_pkg.sv ----
package tic_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets on the special function register port
    localparam logic [7:0] OFS_CONTROL = 8'hA1; // timekeeper_control
    localparam logic [7:0] OFS_FRAC = 8'hA2; // fraction_count
    localparam logic [7:0] OFS_SEC = 8'hA3; // s_unit_count
    localparam logic [7:0] OFS_MIN = 8'hA4; // m_unit_count
    localparam logic [7:0] OFS_HOUR = 8'hA5; // hour_count
    localparam logic [7:0] OFS_TARGET = 8'hA6; // interval_target

    // value of every register after power-on
    localparam logic [7:0] RESET_VALUE = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // control field positions
    localparam int CTRL_CLK_EN = 0; // timebase_clock_enable
    localparam int CTRL_IVAL_EN = 1; // interval_count_enable
    localparam int CTRL_FLAG = 2; // interval_match_flag
    localparam int CTRL_ONESHOT = 3; // one_shot_select
    localparam int CTRL_BASE_LO = 4; // interval_base_select_lo
    localparam int CTRL_BASE_HI = 5; // interval_base_select_hi
    localparam int CTRL_DAYHOUR = 6; // day_hour_select
    localparam int CTRL_UNUSED = 7; // not implemented, reads zero

    ////////////////////////////////////////////////////////////////////////////
    // last value of each counter before it wraps to zero
    localparam logic [7:0] FRAC_LAST = 8'h7F; // 127
    localparam logic [7:0] SIXTY_LAST = 8'h3B; // 59
    localparam logic [7:0] HOUR_DAY_LAST = 8'h17; // 23
    localparam logic [7:0] HOUR_FULL_LAST = 8'hFF; // 255

    ////////////////////////////////////////////////////////////////////////////
    // crystal and fraction rates
    localparam int XTAL_HZ = 32768; // crystal frequency
    localparam int FRAC_HZ = 128; // fraction steps per second
    localparam int XTAL_PER_FRAC = XTAL_HZ / FRAC_HZ; // crystal edges per step
    localparam logic [7:0] XTAL_DIV_LAST = 8'(XTAL_PER_FRAC - 1);

    // interval timebase selection
    typedef enum logic [1:0] {
        BASE_FRAC = 2'h0,
        BASE_SEC = 2'h1,
        BASE_MIN = 2'h2,
        BASE_HOUR = 2'h3
    } base_t;

    // register access sequencer, one-hot
    typedef enum logic [1:0] {
        ACC_IDLE = 2'h1,
        ACC_BUSY = 2'h2
    } access_state_t;

endpackage

// ---- core/xtal_step_gen.sv ----
// brings the crystal into the core clock domain and divides it
module xtal_step_gen (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic xtal_in,
    output logic xtal_tick,
    output logic frac_step
);

    logic sync_a; // first stage, read only by sync_b
    logic sync_b; // second stage, safe to use
    logic sync_prev; // delayed copy for the rising edge
    logic [7:0] div_cnt; // crystal edges within one fraction step

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser on the crystal pin
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_a <= xtal_in;
            sync_b <= sync_a;
            sync_prev <= sync_b;
        end
    end

    // one core cycle per crystal rising edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            xtal_tick <= 1'b0;
        end else begin
            xtal_tick <= sync_b & ~sync_prev;
        end
    end

    // divide by 256 for the 1/128 s step; pulse lands on a crystal tick
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 8'h00;
            frac_step <= 1'b0;
        end else begin
            frac_step <= 1'b0;
            if (sync_b & ~sync_prev) begin
                div_cnt <= div_cnt + 8'h01;
                frac_step <= (div_cnt == tic_pkg::XTAL_DIV_LAST);
            end
        end
    end

endmodule

// ---- test/time_interval_counter_tb_top.sv ----
`define check_eq(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end

module time_interval_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    logic sys_clk = 1'b0; // core clock, 250 MHz
    logic nrst = 1'b0; // active low reset
    logic xtal_in = 1'b0; // fast stand-in for the crystal
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic tic_irq_enable = 1'b1;
    logic power_down = 1'b0;
    logic [7:0] sfr_rdata;
    logic sfr_busy;
    logic irq_req;
    logic wake_req;
    int failures = 0; // mismatches seen
    int n_tests = 0; // comparisons made
    int cyc = 0; // free cycle count, for interval timing
    // rollover cases: starting hour, control value, hour expected after the carry
    logic [7:0] hs[3] = '{8'h17, 8'h17, 8'hff};
    logic [7:0] cs[3] = '{8'h41, 8'h01, 8'h01};
    logic [7:0] he[3] = '{8'h00, 8'h18, 8'h00};

    // crystal toggles on the core falling edges so rising-edge sampling never races
    always #2 sys_clk = ~sys_clk;
    always #16 xtal_in = ~xtal_in;
    always @(posedge sys_clk) cyc <= cyc + 1;

    time_interval_counter time_interval_counter_i (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .xtal_in(xtal_in),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .tic_irq_enable(tic_irq_enable),
        .power_down(power_down),
        .sfr_rdata(sfr_rdata),
        .sfr_busy(sfr_busy),
        .irq_req(irq_req),
        .wake_req(wake_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // closing report, reached from the main sequence and every timeout
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one register access: request held for the taking edge, then wait for busy to fall
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        @(posedge sys_clk);
        sfr_wr <= w;
        sfr_rd <= ~w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        for (n = 0; n < 20000; n++) begin
            @(posedge sys_clk);
            #1;
            if (sfr_busy === 1'b0) break;
        end
        q = sfr_rdata;
        if (n >= 20000) begin
            failures++;
            $display("CHECK FAILED sfr_busy expected 0 seen %b", sfr_busy);
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        access(1'b0, a, 8'h00, q);
    endtask

    // time registers are only preloaded with the timebase stopped
    task automatic set_time(input logic [7:0] h, m, s, f);
        wr(tic_pkg::OFS_FRAC, f);
        wr(tic_pkg::OFS_SEC, s);
        wr(tic_pkg::OFS_MIN, m);
        wr(tic_pkg::OFS_HOUR, h);
    endtask

    // read a register until it leaves a known value; a step is at most 2048 cycles
    task automatic poll(input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
        int k;
        for (k = 0; k < 600; k++) begin
            rd(a, q);
            if (q !== v) break;
        end
        if (k >= 600) begin
            failures++;
            $display("CHECK FAILED poll expected change seen %h", q);
            results();
        end
    endtask

    task automatic wait_irq(input int maxc);
        int n;
        for (n = 0; n < maxc; n++) begin
            @(posedge sys_clk);
            #1;
            if (irq_req === 1'b1) break;
        end
        if (n >= maxc) begin
            failures++;
            $display("CHECK FAILED irq_req expected 1 seen %b", irq_req);
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] q;
        logic [7:0] f;
        logic [7:0] s;
        logic [7:0] m;
        logic seen;
        int t1;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        // every register starts at zero
        for (int i = 0; i < 6; i++) begin
            rd(8'(tic_pkg::OFS_CONTROL + 8'(i)), q);
            `check_eq("reg reset", tic_pkg::RESET_VALUE, q)
        end
        wr(tic_pkg::OFS_CONTROL, 8'hf0);
        rd(tic_pkg::OFS_CONTROL, q);
        `check_eq("ctrl bit7", 8'h70, q)
        $display("test registers done");
        // the carry chain runs with the part in power-down: time must keep counting
        @(posedge sys_clk);
        power_down <= 1'b1;
        // full carry chain from fraction to hours, both hour modes
        for (int i = 0; i < 3; i++) begin
            wr(tic_pkg::OFS_CONTROL, 8'h00);
            set_time(hs[i], 8'h3b, 8'h3b, 8'h7f);
            wr(tic_pkg::OFS_CONTROL, cs[i]);
            poll(tic_pkg::OFS_HOUR, hs[i], q);
            `check_eq("hour", he[i], q)
            rd(tic_pkg::OFS_MIN, q);
            `check_eq("min", 8'h00, q)
            rd(tic_pkg::OFS_SEC, q);
            `check_eq("sec", 8'h00, q)
            rd(tic_pkg::OFS_FRAC, q);
            `check_eq("frac", 8'h00, q)
            wr(tic_pkg::OFS_CONTROL, cs[i] & 8'hfe);
            rd(tic_pkg::OFS_SEC, q);
            `check_eq("sec restored", 8'h3b, q)
            rd(tic_pkg::OFS_HOUR, q);
            `check_eq("hour restored", hs[i], q)
        end
        @(posedge sys_clk);
        power_down <= 1'b0;
        $display("test rollover done");
        // one-shot interval of three fraction steps
        wr(tic_pkg::OFS_CONTROL, 8'h00);
        wr(tic_pkg::OFS_TARGET, 8'h03);
        wr(tic_pkg::OFS_CONTROL, 8'h0b);
        wait_irq(4 * 2048 + 200);
        rd(tic_pkg::OFS_CONTROL, q);
        `check_eq("one-shot ctrl", 8'h0d, q)
        `check_eq("irq", 1'b1, irq_req)
        @(posedge sys_clk);
        power_down <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        `check_eq("wake", 1'b1, wake_req)
        @(posedge sys_clk);
        power_down <= 1'b0;
        tic_irq_enable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        `check_eq("irq masked", 1'b0, irq_req)
        @(posedge sys_clk);
        tic_irq_enable <= 1'b1;
        repeat (3000) @(posedge sys_clk);
        rd(tic_pkg::OFS_CONTROL, q);
        `check_eq("flag held", 8'h0d, q)
        wr(tic_pkg::OFS_CONTROL, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        `check_eq("irq cleared", 1'b0, irq_req)
        $display("test one-shot done");
        // auto-reload: next match exactly two steps after the last
        wr(tic_pkg::OFS_TARGET, 8'h02);
        wr(tic_pkg::OFS_CONTROL, 8'h03);
        wait_irq(3 * 2048 + 200);
        t1 = cyc;
        wr(tic_pkg::OFS_CONTROL, 8'h03);
        wait_irq(5000);
        `check_eq("reload period", 4096, cyc - t1)
        rd(tic_pkg::OFS_CONTROL, q);
        `check_eq("reload ctrl", 8'h07, q)
        wr(tic_pkg::OFS_CONTROL, 8'h01);
        repeat (2) @(posedge sys_clk);
        seen = 1'b0;
        repeat (5000) begin
            @(posedge sys_clk);
            #1;
            seen = seen | irq_req;
        end
        `check_eq("stopped counter", 1'b0, seen)
        $display("test auto-reload done");
        // seconds, minutes and hours bases: no match unless the unit below wraps on the next step
        wr(tic_pkg::OFS_TARGET, 8'h01);
        for (int b = 1; b < 4; b++) begin
            for (int p = 0; p < 2; p++) begin
                f = (b == 1 && p == 0) ? 8'h7e : 8'h7f;
                s = (b == 1) ? 8'h00 : ((b == 2 && p == 0) ? 8'h3a : 8'h3b);
                m = (b == 3) ? ((p == 1) ? 8'h3b : 8'h3a) : 8'h00;
                wr(tic_pkg::OFS_CONTROL, 8'h00);
                set_time(8'h00, m, s, f);
                wr(tic_pkg::OFS_CONTROL, 8'h03 | 8'(b << 4));
                poll(tic_pkg::OFS_FRAC, f, q);
                repeat (2) @(posedge sys_clk);
                #1;
                `check_eq("base match", 1'(p), irq_req)
            end
        end
        wr(tic_pkg::OFS_CONTROL, 8'h00);
        $display("test bases done");
        results();
    end
endmodule
